/* File: inc/sop_pkg.sv */
// Constants and types for the converter result-port controller
package sop_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_MHZ       = 100;  // System clock rate
    localparam int unsigned T_CONV_NS     = 1750; // Conversion time
    localparam int unsigned T_ACQ_NS      = 250;  // Acquisition interval
    localparam int unsigned T_SCK_HALF_NS = 20;   // Internal serial clock half period
    // Least times round up to whole cycles
    localparam int unsigned CONV_CYC = (T_CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned ACQ_CYC  = (T_ACQ_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SCK_HALF = (T_SCK_HALF_NS * CLK_MHZ + 999) / 1000;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] A_CFG  = 8'h00; // Configuration, read/write
    localparam logic [7:0] A_STAT = 8'h04; // Live state, read-only
    localparam logic [7:0] A_RES  = 8'h08; // Latched result, read-only
    localparam logic [7:0] A_IST  = 8'h0c; // Sticky events, read-only
    localparam logic [7:0] A_IEN  = 8'h10; // Event enable, read/write
    localparam logic [7:0] A_ICLR = 8'h14; // Event clear, write-only

    // Configuration fields
    localparam int unsigned CFG_SERIAL_MODE  = 0;
    localparam int unsigned CFG_CLK_SOURCE   = 1;
    localparam int unsigned CFG_CLK_INVERT   = 2;
    localparam int unsigned CFG_FRAME_INVERT = 3;
    localparam int unsigned CFG_READ_TIMING  = 4;
    localparam int unsigned CFG_CODING       = 5;
    localparam int unsigned CFG_POWER_DOWN   = 6;
    localparam int unsigned CFG_LOW_POWER    = 7;
    localparam int unsigned CFG_FAST         = 8;
    localparam logic [8:0]  CFG_RST          = 9'h020; // Parallel, straight binary

    // Event bits
    localparam int unsigned EV_DONE    = 0;
    localparam int unsigned EV_OVERRUN = 1;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Data pins with a serial meaning
    localparam int unsigned PIN_SDO = 8;
    localparam int unsigned PIN_SCK = 9;
    localparam int unsigned PIN_FRM = 10;
    localparam int unsigned PIN_OVR = 11;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_ACQ  = 2'b10
    } sop_state_t;

    // All state of the controller
    typedef struct packed {
        logic        cnv_s1, cnv_s2, cnv_q;  // Start request, active high
        logic        rst_s1, rst_s2;         // Reset pin
        logic        cs_s1, cs_s2;           // Chip select, active high
        logic        rd_s1, rd_s2;           // Read strobe, active high
        logic        sck_s1, sck_s2, sck_q;  // External serial clock
        sop_state_t  st;
        logic [15:0] cnt;
        logic [7:0]  div;
        logic [15:0] result;
        logic [15:0] shreg;
        logic [4:0]  bitcnt;
        logic        reading, avail, int_sck, ovr;
        logic [8:0]  cfg;
        logic [1:0]  ist, ien;
        logic        aw_got, w_got, bvalid, rvalid;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
    } sop_regs_t;

endpackage

/* File: hw/sop_port_ctrl.sv */
// Conversion control and result-output port of a 16-bit converter
//
// Summary of operation
// - Clock invert high: update data on falling edge
// - Parallel mode: bits 9-11 on serial pins
// - Serial clock pin out if internal, in otherwise
// - Internal clock: frame marker during read, polarity selectable
// - External clock: conversion end aborts read, pulses overrun
// - Bits 12 to 15 outputs whenever the bus is enabled
// - Busy from start until result latched
// - Output bus enabled only with select and strobe
// - Reset pin resets logic, aborts conversion
// - Power-down: finish current, refuse new conversions
// - Start falling edge holds sample, starts conversion
// - Low-power, fast off: start still low after acquisition converts
// - Source select low internal clock, high external
// - External, no invert: update on rising edge
// - Result MSB first, binary or two's complement
// - Read timing select, internal clock: read during or after conversion
`timescale 1ns/1ps
`default_nettype none

module sop_port_ctrl #(
    parameter int unsigned CONV_CYC = sop_pkg::CONV_CYC, // Conversion length
    parameter int unsigned ACQ_CYC  = sop_pkg::ACQ_CYC,  // Acquisition length
    parameter int unsigned SCK_HALF = sop_pkg::SCK_HALF  // Internal clock half period
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq,
    // Converter pins
    input  wire logic        convert_start_n,
    input  wire logic        chip_select_n,
    input  wire logic        read_strobe_n,
    input  wire logic        reset_req,
    output logic             busy,
    input  wire logic [15:0] port_in,
    output logic [15:0]      port_out,
    output logic [15:0]      port_oe,
    // Code from the analog array, valid at conversion end
    input  wire logic [15:0] conv_code
);

    // ************************************************************
    // State and decoded controls
    // ************************************************************
    sop_pkg::sop_regs_t s;      // Registered state
    sop_pkg::sop_regs_t next_s; // Its next value

    logic serial_parallel_select; // High: serial port
    logic clock_source_select;    // High: host supplies clock
    logic serial_clock_invert;
    logic frame_marker_invert;
    logic read_timing_select;     // High: read during conversion
    logic output_coding_select;   // High: straight binary
    logic power_down_req;
    logic low_power_select;
    logic fast_select;
    logic bus_en;                 // Select and strobe both active
    logic cnv_fall;               // Start pin falling edge
    logic sck_rise;
    logic sck_fall;
    logic upd_ext;                // Update edge of host clock
    logic conv_end;               // Last cycle of a conversion
    logic start;                  // Begin a conversion
    logic ovr_evt;                // Read lost to a new result
    logic [1:0]  clr;             // Event clear bits
    logic [15:0] wm;              // Byte-lane write mask

    assign serial_parallel_select = s.cfg[sop_pkg::CFG_SERIAL_MODE];
    assign clock_source_select    = s.cfg[sop_pkg::CFG_CLK_SOURCE];
    assign serial_clock_invert    = s.cfg[sop_pkg::CFG_CLK_INVERT];
    assign frame_marker_invert    = s.cfg[sop_pkg::CFG_FRAME_INVERT];
    assign read_timing_select     = s.cfg[sop_pkg::CFG_READ_TIMING];
    assign output_coding_select   = s.cfg[sop_pkg::CFG_CODING];
    assign power_down_req         = s.cfg[sop_pkg::CFG_POWER_DOWN];
    assign low_power_select       = s.cfg[sop_pkg::CFG_LOW_POWER];
    assign fast_select            = s.cfg[sop_pkg::CFG_FAST];

    // Active-low pair combined by an OR: both must be low
    assign bus_en   = s.cs_s2 && s.rd_s2;
    assign cnv_fall = s.cnv_s2 && !s.cnv_q;
    assign sck_rise = s.sck_s2 && !s.sck_q;
    assign sck_fall = !s.sck_s2 && s.sck_q;
    // Falling edge when inverted, rising edge otherwise
    assign upd_ext  = serial_clock_invert ? sck_fall : sck_rise;
    // A reset request cancels the latch of a result
    assign conv_end = (s.st == sop_pkg::ST_CONV) && (s.cnt == 16'h0000) && !s.rst_s2;
    assign wm       = {{8{s.wstrb[1]}}, {8{s.wstrb[0]}}};

    // ************************************************************
    // Outputs
    // ************************************************************
    assign busy          = (s.st == sop_pkg::ST_CONV);
    assign irq           = |(s.ist & s.ien);
    assign s_axi_awready = !s.aw_got && !s.bvalid;
    assign s_axi_wready  = !s.w_got && !s.bvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = !s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;

    // Pin values: serial functions replace bits 8 to 11
    always_comb begin
        port_out = s.result;
        if (serial_parallel_select) begin
            port_out[7:0]                = 8'h00;
            port_out[sop_pkg::PIN_SDO]   = s.shreg[15];
            port_out[sop_pkg::PIN_SCK]   = s.int_sck ^ serial_clock_invert;
            port_out[sop_pkg::PIN_FRM]   = s.reading ^ frame_marker_invert;
            port_out[sop_pkg::PIN_OVR]   = s.ovr;
        end
    end

    // Drivers on only while the bus is enabled; low bits are inputs in serial
    // mode, and the clock pin turns round when the host supplies it
    assign port_oe = !bus_en ? 16'h0000 :
                     !serial_parallel_select ? 16'hffff :
                     {4'hf, 2'h3, !clock_source_select, 1'b1, 8'h00};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s  = s;
        start   = 1'b0;
        ovr_evt = 1'b0;
        clr     = 2'h0;

        // Two-stage synchronisers; start and host clock add one edge-history stage
        next_s.cnv_s1 = !convert_start_n;
        next_s.cnv_s2 = s.cnv_s1;
        next_s.cnv_q  = s.cnv_s2;
        next_s.rst_s1 = reset_req;
        next_s.rst_s2 = s.rst_s1;
        next_s.cs_s1  = !chip_select_n;
        next_s.cs_s2  = s.cs_s1;
        next_s.rd_s1  = !read_strobe_n;
        next_s.rd_s2  = s.rd_s1;
        next_s.sck_s1 = port_in[sop_pkg::PIN_SCK];
        next_s.sck_s2 = s.sck_s1;
        next_s.sck_q  = s.sck_s2;
        next_s.ovr    = 1'b0; // Overrun is a one-cycle pulse

        // Bus write: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.aw_got = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.aw_got && s.w_got) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = sop_pkg::RESP_OKAY;
            case (s.awaddr)
                sop_pkg::A_CFG: begin
                    next_s.cfg = (s.cfg & ~wm[8:0]) | (s.wdata[8:0] & wm[8:0]);
                end
                sop_pkg::A_IEN: begin
                    if (s.wstrb[0]) next_s.ien = s.wdata[1:0];
                end
                sop_pkg::A_ICLR: begin
                    if (s.wstrb[0]) clr = s.wdata[1:0];
                end
                // Writes to read-only words are dropped
                sop_pkg::A_STAT, sop_pkg::A_RES, sop_pkg::A_IST: begin
                    next_s.bresp = sop_pkg::RESP_OKAY;
                end
                default: begin
                    next_s.bresp = sop_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;

        // Bus read: data answered one cycle after the address
        if (s_axi_arvalid && s_axi_arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = sop_pkg::RESP_OKAY;
            case (s_axi_araddr)
                sop_pkg::A_CFG:  next_s.rdata = {23'h0, s.cfg};
                sop_pkg::A_STAT: next_s.rdata = {27'h0, power_down_req, s.avail,
                                                 s.reading, s.st};
                sop_pkg::A_RES:  next_s.rdata = {16'h0, s.result};
                sop_pkg::A_IST:  next_s.rdata = {30'h0, s.ist};
                sop_pkg::A_IEN:  next_s.rdata = {30'h0, s.ien};
                sop_pkg::A_ICLR: next_s.rdata = 32'h0;
                default: begin
                    next_s.rdata = 32'h0;
                    next_s.rresp = sop_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;

        // Serial read engine
        if (s.reading) begin
            if (!bus_en || !serial_parallel_select) begin
                next_s.reading = 1'b0; // Deselect ends the frame
                next_s.int_sck = 1'b0;
            end else if (clock_source_select) begin
                if (conv_end) begin
                    next_s.reading = 1'b0;
                    ovr_evt        = 1'b1;
                end else if (upd_ext) begin
                    next_s.shreg  = {s.shreg[14:0], 1'b0};
                    next_s.bitcnt = s.bitcnt + 5'd1;
                    if (s.bitcnt == 5'd15) next_s.reading = 1'b0;
                end
            end else if (s.div == 8'h00) begin
                // Own clock: rise updates, fall is the host's sample point
                next_s.div     = 8'(SCK_HALF - 1);
                next_s.int_sck = !s.int_sck;
                if (!s.int_sck) begin
                    next_s.shreg  = {s.shreg[14:0], 1'b0};
                    next_s.bitcnt = s.bitcnt + 5'd1;
                end else if (s.bitcnt == 5'd15) begin
                    next_s.reading = 1'b0; // Last bit sampled
                end
            end else begin
                next_s.div = s.div - 8'd1;
            end
        end else if (bus_en && serial_parallel_select && s.avail &&
                     (clock_source_select || !busy || read_timing_select)) begin
            next_s.reading = 1'b1;
            next_s.avail   = 1'b0;
            next_s.shreg   = s.result; // MSB shown first
            next_s.bitcnt  = 5'd0;
            next_s.int_sck = 1'b1;
            next_s.div     = 8'(SCK_HALF - 1);
        end
        next_s.ovr = ovr_evt;

        // Conversion sequencer
        case (s.st)
            sop_pkg::ST_IDLE: begin
                if (cnv_fall && !power_down_req) start = 1'b1;
            end
            sop_pkg::ST_CONV: begin
                // A pending reset pin skips the latch, so an abort leaves no result
                if (conv_end) begin
                    // Latch with selected coding; busy falls here
                    next_s.st     = sop_pkg::ST_ACQ;
                    next_s.cnt    = 16'(ACQ_CYC - 1);
                    next_s.result = conv_code ^ {!output_coding_select, 15'h0};
                    next_s.avail  = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - 16'd1;
                end
            end
            sop_pkg::ST_ACQ: begin
                if (cnv_fall && !power_down_req) begin
                    start = 1'b1;
                end else if (s.cnt == 16'h0000) begin
                    next_s.st = sop_pkg::ST_IDLE;
                    // Start held low through acquisition converts at once
                    if (low_power_select && !fast_select && s.cnv_s2 && !power_down_req)
                        start = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - 16'd1;
                end
            end
            default: begin
                next_s.st = sop_pkg::ST_IDLE;
            end
        endcase
        if (start) begin
            next_s.st  = sop_pkg::ST_CONV;
            next_s.cnt = 16'(CONV_CYC - 1);
        end

        // Sticky events: a new event beats a clear in the same cycle
        next_s.ist = (s.ist & ~clr) | {ovr_evt, conv_end};

        // Reset pin: abort conversion, idle the read path
        if (s.rst_s2) begin
            next_s.st      = sop_pkg::ST_IDLE;
            next_s.cnt     = 16'h0000;
            next_s.reading = 1'b0;
            next_s.int_sck = 1'b0;
            next_s.ovr     = 1'b0;
            next_s.avail   = 1'b0;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s     <= '0;
            s.cfg <= sop_pkg::CFG_RST;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence ext_read_s;
        serial_parallel_select && clock_source_select && s.reading && bus_en;
    endsequence
    // Read dropped in the pulse cycle; a still enabled bus may restart it after
    sequence ovr_pulse_s;
        (s.ovr && !s.reading) ##1 !s.ovr;
    endsequence

    overrun_pulse_a: assert property (
        ext_read_s ##0 conv_end |=> ovr_pulse_s)
        else $error("overrun not pulsed on lost read");
    ext_edge_a: assert property (
        ext_read_s ##0 (serial_clock_invert ? sck_fall : sck_rise) ##0 !conv_end
        |=> s.bitcnt == $past(s.bitcnt) + 5'd1)
        else $error("serial data not advanced on update edge");
    int_edge_a: assert property (
        (serial_parallel_select && !clock_source_select && s.reading && $past(s.reading)
         && !$rose(s.int_sck)) |-> $stable(s.shreg))
        else $error("serial data changed off update edge");
    busy_start_a: assert property (
        (cnv_fall && !power_down_req && !busy && !s.rst_s2) |=> busy)
        else $error("conversion not started");
    done_latch_a: assert property (
        conv_end |=> !busy && s.avail &&
        s.result == ($past(conv_code) ^ {!$past(output_coding_select), 15'h0}))
        else $error("result not latched at busy fall");
    pd_block_a: assert property (
        (power_down_req && !busy && !s.rst_s2) |=> !busy)
        else $error("conversion started in power-down");
    pin_reset_a: assert property (
        s.rst_s2 |=> !busy && !s.reading && !s.ovr && !s.avail)
        else $error("reset pin did not idle the block");
    lp_restart_a: assert property (
        (s.st == sop_pkg::ST_ACQ && s.cnt == 16'h0000 && low_power_select && !fast_select
         && s.cnv_s2 && !power_down_req && !s.rst_s2) |=> busy)
        else $error("held start did not convert");
    par_pins_a: assert property (
        (!serial_parallel_select && bus_en) |-> port_oe == 16'hffff
        && port_out[11:9] == s.result[11:9])
        else $error("parallel bits 9-11 not driven");
    upper_pins_a: assert property (
        bus_en |-> port_oe[15:12] == 4'hf && port_out[15:12] == s.result[15:12])
        else $error("upper result bits not driven");
    oe_gate_a: assert property (!bus_en |-> port_oe == 16'h0000)
        else $error("pins driven while bus disabled");
    clk_dir_a: assert property (
        (serial_parallel_select && bus_en) |-> port_oe[9] == !clock_source_select)
        else $error("serial clock pin direction wrong");
    frame_a: assert property (
        (serial_parallel_select && !clock_source_select && s.reading)
        |-> port_out[10] != frame_marker_invert)
        else $error("frame marker not active during read");
    msb_first_a: assert property ($rose(s.reading) |-> s.shreg == $past(s.result))
        else $error("read did not start from latched result");
    rts_wait_a: assert property (
        (serial_parallel_select && !clock_source_select && !read_timing_select && busy)
        |=> !$rose(s.reading))
        else $error("read started during conversion");

endmodule // sop_port_ctrl

`default_nettype wire

/* File: test/sop_host_sck.sv */
// Host model that supplies the external serial clock
`timescale 1ns/1ps
`default_nettype none

module sop_host_sck (
    input  wire logic run, // Host clocks a frame
    output var  logic sck  // Host serial clock, 125 ns period
);
    // Clock stands low between frames, toggles only within them
    initial sck = 1'b0;
    always begin
        #62.5;
        sck = run ? ~sck : 1'b0;
    end
endmodule // sop_host_sck

`default_nettype wire

/* File: test/tb_sop_port_ctrl.sv */
// Self-checking bench for the result-port controller
`timescale 1ns/1ps
`default_nettype none

module tb_sop_port_ctrl;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run;
    logic        awready, wready, bvalid, arready, rvalid, irq, busy, sck;
    logic        cnv_n, cs_n, rd_n, rst_req;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [1:0]  bresp, rresp;
    logic [15:0] pout, poe, code, bits;
    int          errors, n_tests, hit;

    // Short conversion keeps the run brief
    sop_port_ctrl #(.CONV_CYC(10)) u_sop_port_ctrl (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq),
        .convert_start_n(cnv_n), .chip_select_n(cs_n), .read_strobe_n(rd_n),
        .reset_req(rst_req), .busy(busy), .port_in({6'h00, sck, 9'h000}),
        .port_out(pout), .port_oe(poe), .conv_code(code));
    sop_host_sck u_sop_host_sck (.run(run), .sck(sck));

    always #5 aclk = ~aclk;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Each channel released at its own ready
    task wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        // One idle edge keeps a following call off the same time step
        @(posedge aclk);
    endtask
    task rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0; rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        got = rdata;
        rready <= 1'b0;
    endtask
    task conv;
        cnv_n <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(32'(busy), 32'h1);
        cnv_n <= 1'b1;
        for (int i = 0; i < 20 && busy === 1'b1; i++) @(posedge aclk);
        chk(32'(busy), 32'h0);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task t_par;
        rd(sop_pkg::A_CFG);
        chk(got, 32'(sop_pkg::CFG_RST));
        rd(8'h40);
        chk(32'(rresp), 32'(sop_pkg::RESP_SLVERR));
        wr(8'h40, 32'h0);
        chk(32'(bresp), 32'(sop_pkg::RESP_SLVERR));
        conv();
        cs_n <= 1'b0; rd_n <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(32'(pout), 32'(code));
        chk(32'(poe), 32'hffff);
        rd_n <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(32'(poe), 32'h0);
        cs_n <= 1'b1;
    endtask
    task t_irq;
        wr(sop_pkg::A_IEN, 32'h1);
        chk(32'(bresp), 32'(sop_pkg::RESP_OKAY));
        @(posedge aclk);
        chk(32'(irq), 32'h1);
        wr(sop_pkg::A_ICLR, 32'h1);
        @(posedge aclk);
        chk(32'(irq), 32'h0);
    endtask
    // External clock, two's complement: MSB first, valid at falls
    task t_ser;
        wr(sop_pkg::A_CFG, 32'h003);
        conv();
        cs_n <= 1'b0; rd_n <= 1'b0;
        repeat (4) @(posedge aclk);
        bits[15] = pout[8];
        chk(32'(poe[9]), 32'h0);
        run <= 1'b1;
        for (int i = 14; i >= 0; i--) begin
            @(negedge sck);
            bits[i] = pout[8];
        end
        run <= 1'b0;
        @(posedge aclk);
        chk(32'(bits), 32'(code ^ 16'h8000));
        cs_n <= 1'b1; rd_n <= 1'b1;
    endtask

    // Power-down refuses a start; reset pin aborts a running conversion
    task t_pd;
        wr(sop_pkg::A_CFG, 32'h060);
        cnv_n <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(32'(busy), 32'h0);
        cnv_n <= 1'b1;
        wr(sop_pkg::A_CFG, 32'(sop_pkg::CFG_RST));
        cnv_n <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(32'(busy), 32'h1);
        rst_req <= 1'b1;
        repeat (4) @(posedge aclk);
        chk(32'(busy), 32'h0);
        rst_req <= 1'b0;
        cnv_n <= 1'b1;
        repeat (15) @(posedge aclk);
        rd(sop_pkg::A_IST);
        chk(got, 32'h0);
    endtask
    // External clock: a conversion ending mid-read loses it, one-cycle flag
    task t_ovr;
        conv();
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (4) @(posedge aclk);
        cnv_n <= 1'b0;
        hit = 0;
        for (int i = 0; i < 30; i++) begin
            @(posedge aclk);
            if (pout[11] === 1'b1) hit++;
        end
        chk(32'(hit), 32'h1);
        cnv_n <= 1'b1;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        rd(sop_pkg::A_IST);
        chk(got, 32'h3);
    endtask
    // Own clock, both inverts: bits valid at pin rises, frame active low
    task t_int;
        wr(sop_pkg::A_CFG, 32'h02d);
        conv();
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge pout[9]);
            bits[i] = pout[8];
            if (i == 15) chk(32'(pout[10]), 32'h0);
        end
        @(posedge aclk);
        chk(32'(pout[10]), 32'h1);
        chk(32'(bits), 32'(code));
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask

    task stop_test;
        if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence, six reset cycles first
    initial begin
        aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; run = 1'b0; cnv_n = 1'b1; cs_n = 1'b1;
        rd_n = 1'b1; rst_req = 1'b0; awaddr = 8'h00; araddr = 8'h00;
        wdata = 32'h0; code = 16'ha5c3; errors = 0; n_tests = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(32'(poe), 32'h0);
        t_par();
        t_irq();
        t_pd();
        t_ser();
        t_ovr();
        t_int();
        stop_test();
    end

    // Hang guard, far beyond the few microseconds needed
    initial begin
        #50000;
        errors++;
        stop_test();
    end
endmodule // tb_sop_port_ctrl

`default_nettype wire
